// *** codec_ctl_pkg.sv ***
// codec port control package: register map, field positions, reset values
// assumes a single 200 MHz system clock domain
`default_nettype none
package codec_ctl_pkg;
  localparam logic [7:0] CTRL0_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] IRQ_MASK_OFFSET = 8'h08;
  localparam logic [7:0] SERVICE_OFFSET = 8'h0C;
  localparam int PORT_EN_BIT = 16;
  localparam int CLK_SRC_BIT = 17;
  localparam int RX_MODE_BIT = 18;
  localparam int TTX_IE_BIT = 19;
  localparam int TRX_IE_BIT = 20;
  localparam int ATX_IE_BIT = 21;
  localparam int ARX_IE_BIT = 22;
  localparam int LOOP_BIT = 23;
  localparam int EXT_DIV_LSB = 24;
  localparam int TSD_LSB = 8;
  localparam int ASD_LSB = 0;
  localparam logic [31:0] CTRL0_WMASK = 32'h03FF7F7F;
  localparam logic [31:0] CTRL0_RESET = 32'h00000000;
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam int FRAME_BITS = 32;
  localparam logic [1:0] EXT_DIV_RESET = 2'h0;
endpackage : codec_ctl_pkg
`default_nettype wire

// *** codec_clk_if.sv ***
// interface between the control bank and its clock/rate generator
// assumes both ends on clk_sys
`default_nettype none
interface codec_clk_if;
  logic run;
  logic use_ext;
  logic [1:0] ext_div;
  logic [6:0] audio_sample_divisor;
  logic [6:0] telecom_sample_divisor;
  logic ext_tick;
  logic int_tick;
  logic frame_tick;
  logic audio_tick;
  logic telecom_tick;
  modport ctl (output run, use_ext, ext_div, audio_sample_divisor, telecom_sample_divisor, ext_tick, int_tick,
    input frame_tick, audio_tick, telecom_tick);
  modport gen (input run, use_ext, ext_div, audio_sample_divisor, telecom_sample_divisor, ext_tick, int_tick,
    output frame_tick, audio_tick, telecom_tick);
endinterface : codec_clk_if
`default_nettype wire

// *** codec_rate_gen.sv ***
// frame and sample rate generator: prescale, divide by 32, divide by asd/tsd
// assumes ticks are one-cycle pulses on clk_sys
`default_nettype none
module codec_rate_gen
  import codec_ctl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  codec_clk_if.gen cif
);
  typedef struct packed {
    logic [1:0] pre;
    logic [4:0] bit_cnt;
    logic [6:0] a_cnt;
    logic [6:0] t_cnt;
    logic frame;
    logic a_tick;
    logic t_tick;
  } gen_state_t;
  gen_state_t st_ff;
  gen_state_t nxt_st;
  logic src_tick;
  logic div_tick;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.frame = 1'b0;
    nxt_st.a_tick = 1'b0;
    nxt_st.t_tick = 1'b0;
    // prescaler only applies to the external clock
    src_tick = cif.use_ext ? cif.ext_tick : cif.int_tick;
    div_tick = 1'b0;
    if (!cif.run) begin
      nxt_st = '0;
    end else if (src_tick) begin
      if (!cif.use_ext || st_ff.pre == cif.ext_div) begin
        nxt_st.pre = 2'h0;
        div_tick = 1'b1;
      end else begin
        nxt_st.pre = st_ff.pre + 2'h1;
      end
    end
    if (div_tick) begin
      nxt_st.bit_cnt = st_ff.bit_cnt + 5'h01;
      if (st_ff.bit_cnt == 5'(FRAME_BITS - 1)) begin
        nxt_st.frame = 1'b1;
        if (st_ff.a_cnt + 7'h01 >= cif.audio_sample_divisor) begin
          nxt_st.a_cnt = 7'h00;
          nxt_st.a_tick = 1'b1;
        end else begin
          nxt_st.a_cnt = st_ff.a_cnt + 7'h01;
        end
        if (st_ff.t_cnt + 7'h01 >= cif.telecom_sample_divisor) begin
          nxt_st.t_cnt = 7'h00;
          nxt_st.t_tick = 1'b1;
        end else begin
          nxt_st.t_cnt = st_ff.t_cnt + 7'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign cif.frame_tick = st_ff.frame;
  assign cif.audio_tick = st_ff.a_tick;
  assign cif.telecom_tick = st_ff.t_tick;
endmodule // codec_rate_gen
`default_nettype wire

// *** codec_port_upper_control.sv ***
// codec serial port control register bank with pin hand-over, clock
// select, receive sampling gate and fifo service interrupts
// assumes a simple one-cycle register port and external clock inputs
// arriving asynchronously on pins
//
// Added by the designer: the register offsets and the strobed register port.
`default_nettype none
module codec_port_upper_control
  import codec_ctl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic irq,
  input wire logic ext_clk_pin,
  input wire logic int_clk_tick,
  input wire logic internal_freq_select,
  input wire logic sync_port_enable,
  input wire logic sync_port_pin_reassign,
  input wire logic telecom_tx_service_req,
  input wire logic telecom_rx_service_req,
  input wire logic audio_tx_service_req,
  input wire logic audio_rx_service_req,
  input wire logic audio_rx_valid,
  input wire logic telecom_rx_valid,
  input wire logic shifter_out,
  input wire logic serial_in_pin,
  output logic shifter_in,
  output logic codec_pins_owned,
  output logic sync_pins_owned,
  output logic sync_uses_alt_pins,
  output logic loopback_active,
  output logic use_ext_clock,
  output logic freq_select_out,
  output logic frame_tick,
  output logic audio_rx_store,
  output logic telecom_rx_store,
  output logic [3:0] fifo_irq_req,
  output logic [3:0] fifo_dma_req
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic [3:0] status;
    logic [3:0] mask;
    logic [31:0] rdata;
    logic [2:0] ext_sync;
    logic a_armed;
    logic t_armed;
    logic a_store;
    logic t_store;
  } ctl_state_t;
  ctl_state_t st_ff;
  ctl_state_t nxt_st;
  logic [3:0] svc;
  logic [3:0] svc_rise;
  logic [3:0] svc_prev_ff;
  logic port_en;
  logic rx_mode;

  codec_clk_if cif ();

  // order: {audio rx, audio tx, telecom rx, telecom tx}, matching bits 22..19
  assign svc = {audio_rx_service_req, audio_tx_service_req,
    telecom_rx_service_req, telecom_tx_service_req};
  assign svc_rise = svc & ~svc_prev_ff;
  assign port_en = st_ff.ctrl[PORT_EN_BIT];
  assign rx_mode = st_ff.ctrl[RX_MODE_BIT];

  function automatic logic [31:0] read_mux(input logic [7:0] a,
      input ctl_state_t s);
    logic [31:0] r;
    r = 32'h00000000;
    if (a == CTRL0_OFFSET) begin
      r = s.ctrl;
    end else if (a == STATUS_OFFSET) begin
      r = {28'h0000000, s.status};
    end else if (a == IRQ_MASK_OFFSET) begin
      r = {28'h0000000, s.mask};
    end else if (a == SERVICE_OFFSET) begin
      r = {28'h0000000, svc};
    end
    return r;
  endfunction

  always_comb begin
    nxt_st = st_ff;
    nxt_st.a_store = 1'b0;
    nxt_st.t_store = 1'b0;
    // external clock: two-flop sync, third flop only for edge detect
    nxt_st.ext_sync = {st_ff.ext_sync[1:0], ext_clk_pin};
    if (reg_write) begin
      if (reg_addr == CTRL0_OFFSET) begin
        nxt_st.ctrl = reg_wdata & CTRL0_WMASK;
      end else if (reg_addr == STATUS_OFFSET) begin
        nxt_st.status = st_ff.status & ~reg_wdata[3:0];
      end else if (reg_addr == IRQ_MASK_OFFSET) begin
        nxt_st.mask = reg_wdata[3:0];
      end
    end
    // set beats a write-one-to-clear in the same cycle
    nxt_st.status = nxt_st.status | svc_rise;
    nxt_st.rdata = reg_read ? read_mux(reg_addr, st_ff) : 32'h00000000;
    if (!port_en) begin
      nxt_st.a_armed = 1'b0;
      nxt_st.t_armed = 1'b0;
    end else if (!rx_mode) begin
      nxt_st.a_store = audio_rx_valid;
      nxt_st.t_store = telecom_rx_valid;
    end else begin
      // first valid word stored, afterwards only on counter timeout
      if (!st_ff.a_armed) begin
        nxt_st.a_store = audio_rx_valid;
        nxt_st.a_armed = audio_rx_valid;
      end else begin
        nxt_st.a_store = cif.audio_tick;
      end
      if (!st_ff.t_armed) begin
        nxt_st.t_store = telecom_rx_valid;
        nxt_st.t_armed = telecom_rx_valid;
      end else begin
        nxt_st.t_store = cif.telecom_tick;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_ff <= '0;
      st_ff.ctrl <= CTRL0_RESET;
      st_ff.status <= STATUS_RESET;
      st_ff.mask <= MASK_RESET;
      svc_prev_ff <= 4'h0;
    end else begin
      st_ff <= nxt_st;
      svc_prev_ff <= svc;
    end
  end

  assign cif.run = port_en;
  assign cif.use_ext = st_ff.ctrl[CLK_SRC_BIT];
  assign cif.ext_div = st_ff.ctrl[EXT_DIV_LSB +: 2];
  assign cif.audio_sample_divisor = st_ff.ctrl[ASD_LSB +: 7];
  assign cif.telecom_sample_divisor = st_ff.ctrl[TSD_LSB +: 7];
  assign cif.ext_tick = st_ff.ext_sync[1] & ~st_ff.ext_sync[2];
  assign cif.int_tick = int_clk_tick;

  codec_rate_gen u_rate (
    .clk_sys(clk_sys),
    .reset(reset),
    .cif(cif)
  );

  assign reg_rdata = st_ff.rdata;
  assign irq = |(st_ff.status & st_ff.mask);
  // enables gate interrupt requests only; dma follows the raw request
  assign fifo_irq_req = svc & st_ff.ctrl[TTX_IE_BIT +: 4];
  assign fifo_dma_req = svc;
  assign loopback_active = st_ff.ctrl[LOOP_BIT];
  // loopback feeds the shifter back to itself and frees the pins
  assign shifter_in = loopback_active ? shifter_out : serial_in_pin;
  assign codec_pins_owned = port_en & ~loopback_active;
  assign sync_pins_owned = sync_port_enable &
    (~port_en | sync_port_pin_reassign);
  assign sync_uses_alt_pins = port_en & sync_port_pin_reassign;
  assign use_ext_clock = cif.use_ext;
  assign freq_select_out = internal_freq_select;
  assign frame_tick = cif.frame_tick;
  assign audio_rx_store = st_ff.a_store;
  assign telecom_rx_store = st_ff.t_store;
endmodule // codec_port_upper_control
`default_nettype wire

// *** codec_ctl_checker.sv ***
// checker: control fields, read path, pin hand-over and fifo irq gating
// assumes binding onto codec_port_upper_control, one clk_sys domain
`default_nettype none
module codec_ctl_checker
  import codec_ctl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic internal_freq_select,
  input wire logic telecom_tx_service_req,
  input wire logic telecom_rx_service_req,
  input wire logic audio_tx_service_req,
  input wire logic audio_rx_service_req,
  input wire logic audio_rx_valid,
  input wire logic telecom_rx_valid,
  input wire logic sync_port_enable,
  input wire logic sync_port_pin_reassign,
  input wire logic sync_pins_owned,
  input wire logic sync_uses_alt_pins,
  input wire logic use_ext_clock,
  input wire logic telecom_rx_store,
  input wire logic shifter_out,
  input wire logic serial_in_pin,
  input wire logic shifter_in,
  input wire logic codec_pins_owned,
  input wire logic loopback_active,
  input wire logic freq_select_out,
  input wire logic audio_rx_store,
  input wire logic [3:0] fifo_irq_req,
  input wire logic [3:0] fifo_dma_req
);
  logic [31:0] ctrl_ff;
  logic [3:0] svc;
  logic mode0;
  assign svc = {audio_rx_service_req, audio_tx_service_req,
    telecom_rx_service_req, telecom_tx_service_req};
  assign mode0 = ctrl_ff[PORT_EN_BIT] && !ctrl_ff[RX_MODE_BIT];
  // shadow of what software wrote, reserved bits dropped
  always_ff @(posedge clk_sys) begin
    if (reset)
      ctrl_ff <= CTRL0_RESET;
    else if (reg_write && reg_addr == CTRL0_OFFSET)
      ctrl_ff <= reg_wdata & CTRL0_WMASK;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  own_pins_a: assert property (codec_pins_owned ==
    (ctrl_ff[PORT_EN_BIT] && !ctrl_ff[LOOP_BIT])) else $error("pin owner");
  loop_flag_a: assert property (loopback_active == ctrl_ff[LOOP_BIT])
    else $error("loopback flag");
  loop_mux_a: assert property (shifter_in ==
    (loopback_active ? shifter_out : serial_in_pin)) else $error("shifter");
  irq_gate_a: assert property (fifo_irq_req ==
    (svc & ctrl_ff[ARX_IE_BIT:TTX_IE_BIT])) else $error("irq gating");
  dma_free_a: assert property (fifo_dma_req == svc)
    else $error("dma request");
  read_ctrl_a: assert property ($past(reg_read) &&
    $past(reg_addr) == CTRL0_OFFSET |-> reg_rdata == ctrl_ff)
    else $error("ctrl readback");
  freq_pass_a: assert property (freq_select_out == internal_freq_select)
    else $error("freq select");
  store_all_a: assert property (mode0 && $past(mode0) |->
    audio_rx_store == $past(audio_rx_valid)) else $error("rx store");
  tstore_all_a: assert property (mode0 && $past(mode0) |->
    telecom_rx_store == $past(telecom_rx_valid)) else $error("tel store");
  sync_own_a: assert property (sync_pins_owned ==
    (sync_port_enable && (!ctrl_ff[PORT_EN_BIT] || sync_port_pin_reassign)))
    else $error("sync owner");
  sync_alt_a: assert property (sync_uses_alt_pins ==
    (ctrl_ff[PORT_EN_BIT] && sync_port_pin_reassign))
    else $error("sync alt pins");
  clk_sel_a: assert property (use_ext_clock == ctrl_ff[CLK_SRC_BIT])
    else $error("clock select");
endmodule // codec_ctl_checker
bind codec_port_upper_control codec_ctl_checker chk (.*);
`default_nettype wire

// *** codec_chip_model.sv ***
// external codec model: bit clock on gpio 21 and receive valid strobes
// assumes clk_sys at 200 MHz; clock stands still while run is low
`default_nettype none
module codec_chip_model (
  input wire logic clk_sys,
  input wire logic run,
  output logic ext_clk_pin,
  output logic audio_rx_valid,
  output logic telecom_rx_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial ext_clk_pin = 1'b0;
  // 10 MHz keeps the divided clock under the 12 MHz ceiling
  always @(posedge clk_sys) begin
    cnt <= cnt + 1;
    if (run && cnt % 10 == 9)
      ext_clk_pin <= !ext_clk_pin;
    audio_rx_valid <= (cnt % 7 == 0);
    telecom_rx_valid <= (cnt % 11 == 0);
  end
endmodule // codec_chip_model
`default_nettype wire

// *** tb_codec_port_upper_control.sv ***
// bench: register bank, fifo irq gating and frame rate per clock source
// assumes codec_chip_model as the external codec
`default_nettype none
module tb_codec_port_upper_control;
  import codec_ctl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, reset = 1, reg_write = 0, reg_read = 0, irq;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, got, d;
  logic int_clk_tick = 0, internal_freq_select = 0, sync_port_enable = 0;
  logic sync_port_pin_reassign = 0, shifter_out = 0, serial_in_pin = 0;
  logic telecom_tx_service_req = 0, telecom_rx_service_req = 0;
  logic audio_tx_service_req = 0, audio_rx_service_req = 0;
  logic ext_clk_pin, audio_rx_valid, telecom_rx_valid, ext_run = 0;
  logic shifter_in, codec_pins_owned, sync_pins_owned, sync_uses_alt_pins;
  logic loopback_active, use_ext_clock, freq_select_out, frame_tick;
  logic audio_rx_store, telecom_rx_store, rnd_on = 0;
  logic [3:0] fifo_irq_req, fifo_dma_req;
  int errors = 0, samples_checked = 0, cyc = 0;
  bit [31:0] seed = 32'h0000DC3D;
  codec_port_upper_control dut (.*);
  codec_chip_model partner (.clk_sys, .run(ext_run), .ext_clk_pin,
    .audio_rx_valid, .telecom_rx_valid);
  initial forever #2.5 clk_sys = ~clk_sys;
  function automatic bit [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    int_clk_tick <= (cyc % 4 == 3);
    if (rnd_on)
      {shifter_out, serial_in_pin, internal_freq_select, sync_port_enable,
        sync_port_pin_reassign, audio_rx_service_req,
        telecom_tx_service_req} <= 7'(xs());
  end
  task automatic chk(string name, logic [31:0] exp, logic [31:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge clk_sys);
    {reg_addr, reg_wdata, reg_write} <= {a, v, 1'b1};
    @(posedge clk_sys);
    reg_write <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge clk_sys);
    {reg_addr, reg_read} <= {a, 1'b1};
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 got = reg_rdata;
  endtask
  task automatic next_tick();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1 n++;
    end while (frame_tick !== 1'b1 && n < 4000);
  endtask
  task automatic frame_gap(int exp);
    int t0;
    repeat (2) next_tick();
    t0 = cyc;
    next_tick();
    chk("frame_gap", exp, cyc - t0);
  endtask
  task automatic give_verdict();
    if (errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #300000;
    errors++;
    give_verdict();
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    rd(CTRL0_OFFSET);
    chk("ctrl_reset", CTRL0_RESET, got);
    for (int i = 0; i < 6; i++) begin
      d = xs();
      wr(CTRL0_OFFSET, d);
      rd(CTRL0_OFFSET);
      chk("ctrl", d & CTRL0_WMASK, got);
    end
    wr(8'hF0, xs());
    rd(8'hF0);
    chk("unmapped", 32'h0, got);
    for (int b = 0; b < 4; b++) begin
      {audio_rx_service_req, audio_tx_service_req, telecom_rx_service_req,
        telecom_tx_service_req} <= 4'(1 << b);
      wr(IRQ_MASK_OFFSET, 32'(1 << b));
      wr(CTRL0_OFFSET, 32'(1 << (TTX_IE_BIT + b)));
      chk("irq_req", 1 << b, fifo_irq_req);
      chk("irq", 1, irq);
      wr(CTRL0_OFFSET, 32'h0);
      chk("irq_req_off", 0, fifo_irq_req);
      chk("dma_req", 1 << b, fifo_dma_req);
      {audio_rx_service_req, audio_tx_service_req, telecom_rx_service_req,
        telecom_tx_service_req} <= 4'h0;
      rd(STATUS_OFFSET);
      chk("status", 1 << b, got);
      wr(STATUS_OFFSET, 32'(1 << b));
      rd(STATUS_OFFSET);
      chk("status_clr", 0, got);
      chk("irq_clr", 0, irq);
    end
    ext_run <= 1'b1;
    for (int n = 0; n < 4; n++) begin
      wr(CTRL0_OFFSET, 32'h00030000 | (n << EXT_DIV_LSB));
      frame_gap(FRAME_BITS * (n + 1) * 20);
    end
    wr(CTRL0_OFFSET, 32'h03010000);
    frame_gap(FRAME_BITS * 4);
    rnd_on <= 1'b1;
    wr(CTRL0_OFFSET, 32'h00790000);
    repeat (200) @(posedge clk_sys);
    wr(CTRL0_OFFSET, 32'h00810000);
    repeat (50) @(posedge clk_sys);
    // sampling mode one on the internal clock, stores gated by sample ticks
    wr(CTRL0_OFFSET, 32'h00050202);
    repeat (400) @(posedge clk_sys);
    rd(CTRL0_OFFSET);
    chk("ctrl_mode1", 32'h00050202, got);
    give_verdict();
  end
endmodule // tb_codec_port_upper_control
`default_nettype wire
